// ---- sar_readout_params.svh ----
// Constants for the converter sequencing and serial readout block
`ifndef SAR_READOUT_PARAMS_SVH
`define SAR_READOUT_PARAMS_SVH

`define RESULT_BITS        12
`define LEAD_ZERO_BITS     4
`define FRAME_BITS         16
`define CONV_CYCLES        5'd16
`define CYCLE_CNT_W        5
`define CLK_PERIOD_NS      5
`define OUT_ENABLE_MAX_NS  20
`define OUT_RELEASE_MAX_NS 35
`define OUT_ENABLE_CYCLES  (`OUT_ENABLE_MAX_NS / `CLK_PERIOD_NS)
`define OUT_RELEASE_CYCLES (`OUT_RELEASE_MAX_NS / `CLK_PERIOD_NS)
`define SYNC_LATENCY       3

`endif

// ---- sar_readout_pkg.sv ----
// Types shared by the converter sequencing and serial readout block
package sar_readout_pkg;
    typedef enum logic [1:0] {
        st_power_down = 2'b00,
        st_acquire    = 2'b01,
        st_convert    = 2'b10
    } conv_state_e;

    typedef struct packed {
        logic level;
        logic rise;
        logic fall;
    } pin_edges_s;
endpackage : sar_readout_pkg

// ---- pin_edge_sync.sv ----
// Two-flop synchroniser with edge detection for one pin
module pin_edge_sync
    import sar_readout_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       pin,
    output pin_edges_s      edges
);
    logic meta_q;
    logic sync_q;
    logic prev_q;

    // The first stage feeds only the second; edges come from stages two and three
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign edges.level = sync_q;
    assign edges.rise  = sync_q & ~prev_q;
    assign edges.fall  = ~sync_q & prev_q;
endmodule : pin_edge_sync

// ---- sar_adc_serial_readout.sv ----
// Conversion sequencing and serial result readout of a 12-bit SAR converter
`include "sar_readout_params.svh"

// Notes on behaviour
// - A falling select edge leaves power-down, powers the converter and starts acquisition.
// - A rising select edge samples the input at that instant and starts a conversion. The code loads analog_code on the third clock edge after the pin rises.
// - After a conversion the device powers down by itself until the next falling select edge.
// - A conversion lasts exactly 16 serial clock cycles from the rising select edge.
// - The data output leaves high impedance and is driven within 20 ns of the rising select edge.
// - The data output is released within 35 ns of the serial clock fall that ends the conversion.
// - The frame is four zero bits then the 12-bit straight binary result, MSB first.
// - Each output bit changes on a falling edge of the serial clock.
// - The serial clock is the only conversion clock; steps advance only while it runs.
module sar_adc_serial_readout
    import sar_readout_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      rst,
    input  wire logic                      select_n,
    input  wire logic                      serial_clock,
    input  wire logic [`RESULT_BITS-1:0]   analog_code,
    output logic                           result_serial_out,
    output logic                           result_oe_n,
    output logic                           powered_up,
    output logic                           tracking,
    output logic                           converting
);
    // Both delays are met by the synchroniser latency plus one output flop
    localparam int unsigned EN_LAT_OK  = (`SYNC_LATENCY + 1) <= `OUT_ENABLE_CYCLES;
    localparam int unsigned REL_LAT_OK = (`SYNC_LATENCY + 1) <= `OUT_RELEASE_CYCLES;

    pin_edges_s sel_e;
    pin_edges_s sck_e;

    conv_state_e                 state_q;
    conv_state_e                 state_d;
    logic [`CYCLE_CNT_W-1:0]     cnt_q;
    logic [`CYCLE_CNT_W-1:0]     cnt_d;
    logic [`FRAME_BITS-1:0]      shift_q;
    logic [`FRAME_BITS-1:0]      shift_d;
    logic                        out_q;
    logic                        oe_n_q;
    logic                        pwr_q;
    logic                        trk_q;
    logic                        conv_q;
    logic                        out_d;
    logic                        oe_n_d;
    logic                        pwr_d;
    logic                        trk_d;
    logic                        conv_d;

    // Select and the serial clock come from the host's domain
    pin_edge_sync u_sel_sync (
        .clock (clock),
        .rst   (rst),
        .pin   (select_n),
        .edges (sel_e)
    );

    // The clock pin is only sampled: a phase shorter than one clock can be missed
    pin_edge_sync u_sck_sync (
        .clock (clock),
        .rst   (rst),
        .pin   (serial_clock),
        .edges (sck_e)
    );

    // State decodes shared by the edge qualifiers
    wire in_acquire = (state_q == st_acquire);
    wire in_convert = (state_q == st_convert);
    wire start_acq  = sel_e.fall;
    wire start_conv = sel_e.rise && in_acquire;
    wire step       = in_convert && sck_e.fall;
    wire last_step  = step && (cnt_q == `CONV_CYCLES - 5'd1);
    wire [`CYCLE_CNT_W-1:0] cnt_inc = cnt_q + 5'd1;
    wire [`FRAME_BITS-1:0]  frame;
    wire [`FRAME_BITS-1:0]  shift_next;

    // Result field in the low bits, fixed zeros above it
    for (genvar j = 0; j < `FRAME_BITS; j++) begin : g_frame
        if (j < `RESULT_BITS) begin : g_data
            assign frame[j] = analog_code[j];
        end else begin : g_lead
            assign frame[j] = 1'b0;
        end
    end

    // Bit zero refills with zero; out_d forces the pin low once the result is out
    for (genvar b = 0; b < `FRAME_BITS; b++) begin : g_shift
        if (b == 0) begin : g_fill
            assign shift_next[b] = 1'b0;
        end else begin : g_move
            assign shift_next[b] = shift_q[b-1];
        end
    end

    // A select fall always wins: an aborted conversion restarts acquisition
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            st_power_down: begin
                if (start_acq) begin
                    state_d = st_acquire;
                end
            end
            st_acquire: begin
                if (start_conv) begin
                    state_d = st_convert;
                end
            end
            st_convert: begin
                if (start_acq) begin
                    state_d = st_acquire;
                end else if (last_step) begin
                    state_d = st_power_down;
                end
            end
            default: begin
                state_d = st_power_down;
            end
        endcase
    end

    // Counter and shifter move only on a conversion start or a seen clock fall, so a stopped clock freezes them
    always_comb begin
        cnt_d   = cnt_q;
        shift_d = shift_q;
        if (start_conv) begin
            cnt_d   = '0;
            shift_d = frame;
        end else if (step && !start_acq && !last_step) begin
            cnt_d   = cnt_inc;
            shift_d = shift_next;
        end
    end

    // Reset parks the sequencer in power-down with the pin released
    always_ff @(posedge clock) begin
        if (rst) begin
            state_q <= st_power_down;
        end else begin
            state_q <= state_d;
        end
    end

    // The count restarts with every conversion, so an abort leaves no trace
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            shift_q <= '0;
        end else begin
            shift_q <= shift_d;
        end
    end

    // Outputs follow the next state, so each pin moves on the edge after detection
    assign out_d  = (state_d == st_convert) ? shift_d[`FRAME_BITS-1] : 1'b0;
    assign oe_n_d = (state_d != st_convert);
    assign pwr_d  = (state_d != st_power_down);
    assign trk_d  = (state_d == st_acquire);
    assign conv_d = (state_d == st_convert);

    // One flop per pin keeps every output free of decode glitches
    always_ff @(posedge clock) begin
        if (rst) begin
            out_q <= 1'b0;
        end else begin
            out_q <= out_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            oe_n_q <= 1'b1;
        end else begin
            oe_n_q <= oe_n_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pwr_q <= 1'b0;
        end else begin
            pwr_q <= pwr_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            trk_q <= 1'b0;
        end else begin
            trk_q <= trk_d;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            conv_q <= 1'b0;
        end else begin
            conv_q <= conv_d;
        end
    end

    // Ports are driven straight from the flops
    assign result_serial_out = out_q;
    assign result_oe_n       = oe_n_q;
    assign powered_up        = pwr_q;
    assign tracking          = trk_q;
    assign converting        = conv_q;
endmodule : sar_adc_serial_readout

// ---- sar_adc_chk.sv ----
// Checker for the converter sequencing and serial readout block
module sar_adc_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic select_n,
    input wire logic serial_clock,
    input wire logic result_serial_out,
    input wire logic result_oe_n,
    input wire logic powered_up,
    input wire logic tracking,
    input wire logic converting
);
    timeunit 1ns;
    timeprecision 100ps;
    logic       sclk_q;
    logic [4:0] falls_q;
    wire        fall_w = sclk_q && !serial_clock;
    // Counts raw pin falls, so it leads the design by its sync delay
    always_ff @(posedge clock) begin
        sclk_q <= serial_clock;
        falls_q <= (rst || !converting) ? 5'h0 : falls_q + {4'h0, fall_w};
    end
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    sequence conv_start;
        $rose(select_n) && tracking;
    endsequence
    a_fall_powers: assert property ($fell(select_n) |-> ##[1:4] powered_up && tracking)
        else $error("select fall did not power up");
    a_rise_converts: assert property (conv_start |-> ##[1:4] converting && !tracking)
        else $error("select rise did not start conversion");
    a_oe_drive: assert property (conv_start |-> ##[1:4] !result_oe_n)
        else $error("output not driven in time");
    a_conv_length: assert property ($fell(converting) && !tracking |-> falls_q == 5'd16)
        else $error("conversion length wrong");
    a_out_release: assert property (converting && falls_q == 5'd16 |-> ##[1:7] result_oe_n && !powered_up)
        else $error("output not released after conversion");
    a_bit_edge: assert property ($changed(result_serial_out) && $past(converting) |-> !$past(serial_clock, 2))
        else $error("bit changed away from clock fall");
    a_lead_zero: assert property (converting && falls_q < 5'd4 |-> !result_serial_out)
        else $error("leading bit not zero");
    a_idle_quiet: assert property (!powered_up |-> result_oe_n && !converting && !tracking)
        else $error("activity while powered down");
endmodule : sar_adc_chk
bind sar_adc_serial_readout sar_adc_chk i_chk (.clock, .rst, .select_n, .serial_clock,
    .result_serial_out, .result_oe_n, .powered_up, .tracking, .converting);

// ---- host_model.sv ----
// Host serial port model: frames select, drives serial clock, reads bits
module host_model (
    output logic      select_n,
    output logic      serial_clock,
    input  wire logic result_serial_out,
    input  wire logic result_oe_n
);
    timeunit 1ns;
    timeprecision 100ps;
    // No pull on the line: a released output shows the inverse bit
    wire line = result_oe_n ? !result_serial_out : result_serial_out;
    initial begin
        select_n = 1'b1;
        serial_clock = 1'b1;
    end
    task automatic drive_select(input logic level);
        select_n <= level;
    endtask : drive_select
    task automatic frame(output logic [15:0] word);
        select_n <= 1'b0;
        #1400 select_n <= 1'b1;
        #40 word[15] = line;
        for (int i = 14; i >= -1; i--) begin
            serial_clock <= 1'b0;
            #32 serial_clock <= 1'b1;
            if (i >= 0) word[i] = line;
            #32;
        end
        #7500;
    endtask : frame
    task automatic idle_clocks();
        repeat (4) begin
            #32 serial_clock <= 1'b0;
            #32 serial_clock <= 1'b1;
        end
    endtask : idle_clocks
endmodule : host_model

// ---- tb_top.sv ----
// Self-checking bench for the converter sequencing and serial readout block
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic [11:0] analog_code = 12'h000;
    logic        select_n, serial_clock, result_serial_out, result_oe_n;
    logic        powered_up, tracking, converting;
    int          n_mismatch = 0;
    int          check_count = 0;
    wire  [15:0] status = {12'h0, result_oe_n, powered_up, tracking, converting};
    always #2.5 clock = ~clock;
    sar_adc_serial_readout i_dut (.clock, .rst, .select_n, .serial_clock, .analog_code,
        .result_serial_out, .result_oe_n, .powered_up, .tracking, .converting);
    host_model i_host (.select_n, .serial_clock, .result_serial_out, .result_oe_n);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test
    task automatic t_idle();
        i_host.idle_clocks();
        check(status, 16'h0008);
    endtask : t_idle
    task automatic t_frames();
        logic [15:0] word;
        logic [11:0] codes [4] = '{12'h000, 12'hfff, 12'ha5c, 12'h801};
        foreach (codes[k]) begin
            @(posedge clock) analog_code <= codes[k];
            fork
                i_host.frame(word);
                begin
                    #102 check(status, 16'h000e);
                    #1400 check(status, 16'h0005);
                    // Input moves after the rise: the held sample must win
                    @(posedge clock) analog_code <= ~codes[k];
                end
            join
            check(word, {4'h0, codes[k]});
            check(status, 16'h0008);
        end
    endtask : t_frames
    task automatic t_abort();
        logic [15:0] word;
        @(posedge clock) analog_code <= 12'h3c3;
        i_host.drive_select(1'b0);
        #1400 i_host.drive_select(1'b1);
        #100 check(status, 16'h0005);
        i_host.idle_clocks();
        check(status, 16'h0005);
        i_host.drive_select(1'b0);
        #100 check(status, 16'h000e);
        i_host.frame(word);
        check(word, {4'h0, 12'h3c3});
        check(status, 16'h0008);
    endtask : t_abort
    initial begin
        #200us;
        n_mismatch++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        t_idle();
        t_abort();
        t_frames();
        finish_test();
    end
endmodule : tb_top
